//--- vbc_pkg.sv
// shared constants and types for the vco band calibration control block
package vbc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BANK1 = 8'h04;
  localparam logic [7:0] OFF_BANK2 = 8'h08;
  localparam logic [7:0] OFF_READBACK = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // control register fields
  localparam int CTRL_RELOCK_BIT = 0;
  localparam int CTRL_LBW_EN_BIT = 1;
  localparam int CTRL_REFDIV_LSB = 4;
  localparam int REFDIV_W = 3;
  localparam logic [2:0] REFDIV_RST = 3'h1;
  // readback register fields
  localparam int RB_BAND_LSB = 0;
  localparam int RB_FAIL_BIT = 8;
  localparam int RB_LOCK_BIT = 9;
  localparam int RB_BUSY_BIT = 10;
  localparam int RB_CP_LSB = 12;
  localparam int RB_VCO_LSB = 20;
  localparam int RB_DIV_LSB = 24;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_LOCK_BIT = 2;
  // band search limits
  localparam int BAND_W = 7;
  localparam logic [6:0] BAND_LOW = 7'h00;
  localparam logic [6:0] BAND_HIGH = 7'h7f;
  // programming bank holds target lo frequency in mhz
  localparam int FREQ_W = 13;
  localparam logic [12:0] BANK_RST = 13'h03e8;
  // vco ranges in mhz after the output divider is undone
  localparam logic [18:0] VCO_MIN_MHZ = 19'h00a8c; // 2700
  localparam logic [18:0] VCO1_TOP_MHZ = 19'h00e10; // 3600
  localparam logic [18:0] VCO2_TOP_MHZ = 19'h01194; // 4500
  localparam int DIV_LOG_MAX = 5; // divide by 32
  // charge pump
  localparam int CP_W = 6;
  localparam logic [5:0] CP_DEF = 6'h1f;
  localparam logic [5:0] CP_BASE = 6'h10;

  // settings sent to the analog core
  typedef struct packed {
    logic [1:0] vco_sel;
    logic [2:0] div_log;
    logic [6:0] band;
    logic [5:0] cp_current;
    logic loop_enable;
  } vbc_ana_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } vbc_apb_req_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SELECT, ST_BAND, ST_LBW, ST_LOCK
  } vbc_state_t;
endpackage

//--- vbc_ref_div.sv
// reference divider producing the phase detector tick
`timescale 1ns/1ps
module vbc_ref_div (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ref_tick,
  input wire logic [2:0] ratio,
  output logic pfd_tick
);
  logic [2:0] cnt_reg;
  logic [2:0] ratio_eff;

  // a ratio of zero behaves as one
  assign ratio_eff = (ratio == 3'h0) ? 3'h1 : ratio;

  // count reference edges, tick on the last one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
      pfd_tick <= 1'b0;
    end else begin
      pfd_tick <= 1'b0;
      if (ref_tick) begin
        if (cnt_reg + 3'h1 >= ratio_eff) begin
          cnt_reg <= 3'h0;
          pfd_tick <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  end
endmodule

//--- vbc_band_search.sv
// linear coarse band search, one capacitance step per phase detector tick
`timescale 1ns/1ps
module vbc_band_search (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic step_tick,
  input wire logic freq_above,
  output logic [6:0] band,
  output logic busy,
  output logic done,
  output logic fail
);
  // each step adds capacitance, lowering the vco; stop once at or below target
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      band <= vbc_pkg::BAND_LOW;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        band <= vbc_pkg::BAND_LOW;
        busy <= 1'b1;
        fail <= 1'b0;
      end else if (busy && step_tick) begin
        if (!freq_above || band == vbc_pkg::BAND_HIGH) begin
          busy <= 1'b0;
          done <= 1'b1;
          fail <= (band == vbc_pkg::BAND_HIGH) || (band == vbc_pkg::BAND_LOW);
        end else begin
          band <= band + 7'h01;
        end
      end
    end
  end
endmodule

//--- vbc_top.sv
// vco auto-select and coarse band calibration control with apb registers
`timescale 1ns/1ps
module vbc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic analog_enable_pin,
  input wire logic bank_select_pin,
  input wire logic ref_tick,
  input wire logic freq_above,
  input wire logic tune_in_window,
  output vbc_pkg::vbc_ana_t ana_ctrl,
  output logic pll_lock,
  output logic irq
);
  vbc_pkg::vbc_apb_req_t req;
  vbc_pkg::vbc_state_t state_reg;
  vbc_pkg::vbc_state_t state_next;
  logic relock_reg;
  logic lbw_en_reg;
  logic [2:0] refdiv_reg;
  logic [12:0] first_programming_bank;
  logic [12:0] second_programming_bank;
  logic [6:0] coarse_tune_result;
  logic coarse_tune_fail_flag;
  logic [1:0] vco_reg;
  logic [2:0] div_reg;
  logic [5:0] cp_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_set;
  logic en_prev_reg;
  logic lock_prev_reg;
  logic start_cal;
  logic wr_access;
  logic rd_setup;
  logic pfd_tick;
  logic [6:0] srch_band;
  logic srch_busy;
  logic srch_done;
  logic srch_fail;
  logic [12:0] active_freq;
  logic [4:0] pick;

  // reports whether an address maps to a register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == vbc_pkg::OFF_CTRL) || (a == vbc_pkg::OFF_BANK1) ||
               (a == vbc_pkg::OFF_BANK2) || (a == vbc_pkg::OFF_READBACK) ||
               (a == vbc_pkg::OFF_IRQ_STAT) || (a == vbc_pkg::OFF_IRQ_MASK);
  endfunction

  // pick output divider and vco: {vco, div_log}
  function automatic logic [4:0] vco_pick(input logic [12:0] f);
    logic [18:0] fv;
    logic [2:0] k;
    fv = {6'h00, f};
    k = 3'h0;
    for (int i = 0; i < vbc_pkg::DIV_LOG_MAX; i++) begin
      if (fv < vbc_pkg::VCO_MIN_MHZ) begin
        fv = {fv[17:0], 1'b0};
        k = k + 3'h1;
      end
    end
    if (fv < vbc_pkg::VCO1_TOP_MHZ) begin
      vco_pick = {2'h0, k};
    end else if (fv < vbc_pkg::VCO2_TOP_MHZ) begin
      vco_pick = {2'h1, k};
    end else begin
      vco_pick = {2'h2, k};
    end
  endfunction

  // bus request bundle
  assign req.psel = psel;
  assign req.penable = penable;
  assign req.pwrite = pwrite;
  assign req.paddr = paddr;
  assign req.pwdata = pwdata;

  // zero wait state slave
  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !addr_hit(req.paddr);
  assign wr_access = req.psel && req.penable && req.pwrite && addr_hit(req.paddr);
  assign rd_setup = req.psel && !req.penable && !req.pwrite;

  // calibration triggers
  assign start_cal = analog_enable_pin && ((!en_prev_reg) || relock_reg);
  assign active_freq = bank_select_pin ? second_programming_bank
                                       : first_programming_bank;
  assign pick = vco_pick(active_freq);

  vbc_ref_div u_ref_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ref_tick(ref_tick),
    .ratio(refdiv_reg),
    .pfd_tick(pfd_tick)
  );

  vbc_band_search u_search (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(state_reg == vbc_pkg::ST_SELECT),
    .abort(!analog_enable_pin),
    .step_tick(pfd_tick),
    .freq_above(freq_above),
    .band(srch_band),
    .busy(srch_busy),
    .done(srch_done),
    .fail(srch_fail)
  );

  // control register, relock bit clears itself
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      relock_reg <= 1'b0;
      lbw_en_reg <= 1'b0;
      refdiv_reg <= vbc_pkg::REFDIV_RST;
    end else begin
      relock_reg <= 1'b0;
      if (wr_access && req.paddr == vbc_pkg::OFF_CTRL) begin
        relock_reg <= req.pwdata[vbc_pkg::CTRL_RELOCK_BIT];
        lbw_en_reg <= req.pwdata[vbc_pkg::CTRL_LBW_EN_BIT];
        refdiv_reg <= req.pwdata[vbc_pkg::CTRL_REFDIV_LSB +: vbc_pkg::REFDIV_W];
      end
    end
  end

  // programming banks
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      first_programming_bank <= vbc_pkg::BANK_RST;
      second_programming_bank <= vbc_pkg::BANK_RST;
    end else if (wr_access) begin
      if (req.paddr == vbc_pkg::OFF_BANK1) begin
        first_programming_bank <= req.pwdata[vbc_pkg::FREQ_W-1:0];
      end
      if (req.paddr == vbc_pkg::OFF_BANK2) begin
        second_programming_bank <= req.pwdata[vbc_pkg::FREQ_W-1:0];
      end
    end
  end

  // edge history for enable pin and lock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_prev_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= analog_enable_pin;
      lock_prev_reg <= pll_lock;
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vbc_pkg::ST_IDLE: begin
        if (start_cal) begin
          state_next = vbc_pkg::ST_SELECT;
        end
      end
      vbc_pkg::ST_SELECT: begin
        state_next = vbc_pkg::ST_BAND;
      end
      vbc_pkg::ST_BAND: begin
        if (srch_done) begin
          state_next = lbw_en_reg ? vbc_pkg::ST_LBW : vbc_pkg::ST_LOCK;
        end
      end
      vbc_pkg::ST_LBW: begin
        if (pfd_tick) begin
          state_next = vbc_pkg::ST_LOCK;
        end
      end
      vbc_pkg::ST_LOCK: begin
        if (start_cal) begin
          state_next = vbc_pkg::ST_SELECT;
        end
      end
      default: state_next = vbc_pkg::ST_IDLE;
    endcase
    if (!analog_enable_pin) begin
      state_next = vbc_pkg::ST_IDLE;
    end else if (start_cal) begin
      state_next = vbc_pkg::ST_SELECT;
    end
  end

  // sequencer state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= vbc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // vco and divider latched from the active bank
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vco_reg <= 2'h0;
      div_reg <= 3'h0;
    end else if (state_reg == vbc_pkg::ST_SELECT) begin
      vco_reg <= pick[4:3];
      div_reg <= pick[2:0];
    end
  end

  // charge pump: default, or scaled from band when calibrating bandwidth
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cp_reg <= vbc_pkg::CP_DEF;
    end else if (state_reg == vbc_pkg::ST_LBW && pfd_tick) begin
      cp_reg <= vbc_pkg::CP_BASE + {1'b0, ~srch_band[6:2]};
    end else if (state_reg == vbc_pkg::ST_SELECT && !lbw_en_reg) begin
      cp_reg <= vbc_pkg::CP_DEF;
    end
  end

  // results change only when the search finishes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      coarse_tune_result <= vbc_pkg::BAND_LOW;
      coarse_tune_fail_flag <= 1'b0;
    end else if (srch_done) begin
      coarse_tune_result <= srch_band;
      coarse_tune_fail_flag <= srch_fail;
    end
  end

  // analog settings; loop runs only once a band is held
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ana_ctrl <= '0;
      pll_lock <= 1'b0;
    end else begin
      ana_ctrl.vco_sel <= vco_reg;
      ana_ctrl.div_log <= div_reg;
      ana_ctrl.band <= (srch_busy || srch_done) ? srch_band : coarse_tune_result;
      ana_ctrl.cp_current <= cp_reg;
      ana_ctrl.loop_enable <= (state_next == vbc_pkg::ST_LOCK);
      pll_lock <= (state_next == vbc_pkg::ST_LOCK) && tune_in_window;
    end
  end

  // interrupt events
  assign irq_set[vbc_pkg::IRQ_DONE_BIT] = srch_done;
  assign irq_set[vbc_pkg::IRQ_FAIL_BIT] = srch_done && srch_fail;
  assign irq_set[vbc_pkg::IRQ_LOCK_BIT] = pll_lock != lock_prev_reg;

  // sticky status, write one clears, set wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_access && req.paddr == vbc_pkg::OFF_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~req.pwdata[vbc_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_access && req.paddr == vbc_pkg::OFF_IRQ_MASK) begin
        irq_mask_reg <= req.pwdata[vbc_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read data captured in the setup cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= '0;
      case (req.paddr)
        vbc_pkg::OFF_CTRL: begin
          prdata[vbc_pkg::CTRL_RELOCK_BIT] <= relock_reg;
          prdata[vbc_pkg::CTRL_LBW_EN_BIT] <= lbw_en_reg;
          prdata[vbc_pkg::CTRL_REFDIV_LSB +: vbc_pkg::REFDIV_W] <= refdiv_reg;
        end
        vbc_pkg::OFF_BANK1: prdata[vbc_pkg::FREQ_W-1:0] <= first_programming_bank;
        vbc_pkg::OFF_BANK2: prdata[vbc_pkg::FREQ_W-1:0] <= second_programming_bank;
        vbc_pkg::OFF_READBACK: begin
          prdata[vbc_pkg::RB_BAND_LSB +: vbc_pkg::BAND_W] <= coarse_tune_result;
          prdata[vbc_pkg::RB_FAIL_BIT] <= coarse_tune_fail_flag;
          prdata[vbc_pkg::RB_LOCK_BIT] <= pll_lock;
          prdata[vbc_pkg::RB_BUSY_BIT] <= (state_reg != vbc_pkg::ST_IDLE) &&
                                          (state_reg != vbc_pkg::ST_LOCK);
          prdata[vbc_pkg::RB_CP_LSB +: vbc_pkg::CP_W] <= cp_reg;
          prdata[vbc_pkg::RB_VCO_LSB +: 2] <= vco_reg;
          prdata[vbc_pkg::RB_DIV_LSB +: 3] <= div_reg;
        end
        vbc_pkg::OFF_IRQ_STAT: prdata[vbc_pkg::IRQ_W-1:0] <= irq_stat_reg;
        vbc_pkg::OFF_IRQ_MASK: prdata[vbc_pkg::IRQ_W-1:0] <= irq_mask_reg;
        default: prdata <= '0;
      endcase
    end
  end
endmodule

//--- vbc_top_monitor.sv
// assertion checker for the vco band calibration control block
`timescale 1ns/1ps
module vbc_top_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic analog_enable_pin,
  input wire logic bank_select_pin,
  input wire logic ref_tick,
  input wire logic freq_above,
  input wire logic tune_in_window,
  input wire vbc_pkg::vbc_ana_t ana_ctrl,
  input wire logic pll_lock,
  input wire logic irq
);
  // all checks run on the core clock, quiet in reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_START_LOOP_OFF: assert property (
    $rose(analog_enable_pin) |=> ##1 (!ana_ctrl.loop_enable && !pll_lock))
    else $error("loop still closed after enable edge");
  AST_LOCK_NEEDS_LOOP: assert property (
    pll_lock |-> (ana_ctrl.loop_enable || $past(ana_ctrl.loop_enable)))
    else $error("lock reported with loop open");
  AST_LOCK_FROM_WINDOW: assert property (
    (ana_ctrl.loop_enable && $past(ana_ctrl.loop_enable)) |-> pll_lock == $past(tune_in_window))
    else $error("lock does not follow window detector");
  AST_ZERO_WAIT: assert property (
    (psel && penable) |-> pready)
    else $error("bus access not answered at once");
  AST_UNMAPPED_ERR: assert property (
    (psel && penable && paddr > 8'h14) |-> pslverr)
    else $error("unmapped access without error");
  AST_BAND_STEP: assert property (
    (analog_enable_pin && $past(analog_enable_pin) && ana_ctrl.band != $past(ana_ctrl.band))
    |-> (ana_ctrl.band == $past(ana_ctrl.band) + 7'h01 || ana_ctrl.band == 7'h00))
    else $error("band moved by more than one step");
  AST_DIV_RANGE: assert property (
    ana_ctrl.div_log <= 3'h5)
    else $error("output divider beyond 32");
  AST_RESET_QUIET: assert property (
    $rose(rst_n) |-> (ana_ctrl == '0 && !pll_lock && !irq))
    else $error("outputs not cleared by reset");
endmodule

bind vbc_top vbc_top_monitor i_mon (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .analog_enable_pin, .bank_select_pin, .ref_tick,
  .freq_above, .tune_in_window, .ana_ctrl, .pll_lock, .irq);

//--- vbc_ana_model.sv
// analog core and reference stand-in for the calibration bench
`timescale 1ns/1ps
module vbc_ana_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire vbc_pkg::vbc_ana_t ana_ctrl,
  input wire logic [7:0] stop_band,
  input wire logic window_ok,
  output logic ref_tick,
  output logic freq_above,
  output logic tune_in_window
);
  // reference pulse every second cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) ref_tick <= 1'b0;
    else ref_tick <= !ref_tick;
  end
  // comparator: oscillator above target until band reaches the stop value
  assign freq_above = {1'b0, ana_ctrl.band} < stop_band;
  // window detector sees a settled voltage only with the loop closed
  assign tune_in_window = window_ok && ana_ctrl.loop_enable;
endmodule

//--- test_vbc_top.sv
// self-checking bench for the vco band calibration control block
`timescale 1ns/1ps
module test_vbc_top;
  typedef struct {logic [7:0] stop; logic bank; logic lbw; logic [6:0] band; logic fail;} vbc_row_t;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, en, bank, win, pll_lock, irq;
  logic ref_tick, freq_above, tune_in_window, err;
  logic [7:0] paddr, stop;
  logic [31:0] pwdata, prdata, rd;
  vbc_pkg::vbc_ana_t ana;
  int n_errors = 0;
  int cmp_count = 0;
  vbc_row_t rows [6] = '{'{8'h00, 1'b0, 1'b0, 7'h00, 1'b1}, '{8'h01, 1'b1, 1'b0, 7'h01, 1'b0},
    '{8'h3c, 1'b0, 1'b1, 7'h3c, 1'b0}, '{8'h7e, 1'b1, 1'b0, 7'h7e, 1'b0},
    '{8'h7f, 1'b0, 1'b0, 7'h7f, 1'b1}, '{8'hc8, 1'b1, 1'b0, 7'h7f, 1'b1}};

  vbc_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_enable_pin(en), .bank_select_pin(bank), .ref_tick(ref_tick),
    .freq_above(freq_above), .tune_in_window(tune_in_window), .ana_ctrl(ana),
    .pll_lock(pll_lock), .irq(irq));
  vbc_ana_model i_ana (.core_clk(core_clk), .rst_n(rst_n), .ana_ctrl(ana), .stop_band(stop),
    .window_ok(win), .ref_tick(ref_tick), .freq_above(freq_above),
    .tune_in_window(tune_in_window));

  // 50 mhz clock
  always #10 core_clk = !core_clk;

  // verdict and end of run
  task results();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare seen against expected
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, released one edge after pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // bounded wait for the interrupt line
  task wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      results();
    end
  endtask
  // restart calibration with an enable edge
  task kick();
    en <= 1'b0;
    repeat (2) @(posedge core_clk);
    en <= 1'b1;
    @(posedge core_clk);
  endtask

  // main sequence
  initial begin
    core_clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    en = 0; bank = 0; stop = 0; win = 1;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, vbc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h10);
    apb(1'b0, vbc_pkg::OFF_BANK1, 32'h0);
    chk("bank1 reset", rd, 32'h3e8);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, vbc_pkg::OFF_BANK2, 32'hbb8);
    apb(1'b1, vbc_pkg::OFF_IRQ_MASK, 32'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      stop <= rows[i].stop;
      bank <= rows[i].bank;
      apb(1'b1, vbc_pkg::OFF_CTRL, 32'h10 | {30'h0, rows[i].lbw, 1'b0});
      kick();
      wait_irq();
      repeat (10) @(posedge core_clk);
      apb(1'b0, vbc_pkg::OFF_READBACK, 32'h0);
      chk("band", rd[6:0], rows[i].band);
      chk("fail", rd[8], rows[i].fail);
      chk("div", rd[26:24], rows[i].bank ? 3'h0 : 3'h2);
      chk("vco", rd[21:20], rows[i].bank ? 2'h0 : 2'h1);
      chk("ana band", ana.band, rows[i].band);
      chk("cp", rd[17:12], rows[i].lbw ? 6'h10 + {1'b0, ~rows[i].band[6:2]} : 6'h1f);
      if (!rows[i].fail) chk("lock", rd[9], 1'b1);
      apb(1'b1, vbc_pkg::OFF_IRQ_STAT, 32'h7);
      chk("irq clear", irq, 1'b0);
      $display("row %0d done", i);
    end
    // relock bit restarts while enabled and clears itself
    stop <= 8'h3c;
    apb(1'b1, vbc_pkg::OFF_CTRL, 32'h11);
    wait_irq();
    apb(1'b0, vbc_pkg::OFF_CTRL, 32'h0);
    chk("relock clear", rd[0], 1'b0);
    repeat (10) @(posedge core_clk);
    apb(1'b0, vbc_pkg::OFF_READBACK, 32'h0);
    chk("relock band", rd[6:0], 7'h3c);
    apb(1'b1, vbc_pkg::OFF_IRQ_STAT, 32'h7);
    $display("relock test done");
    // slow search: old result held, lock low, then abort
    stop <= 8'h64;
    apb(1'b1, vbc_pkg::OFF_CTRL, 32'h70);
    kick();
    repeat (40) @(posedge core_clk);
    apb(1'b0, vbc_pkg::OFF_READBACK, 32'h0);
    chk("held band", rd[6:0], 7'h3c);
    chk("busy lock", rd[10:9], 2'h2);
    en <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("abort loop", ana.loop_enable, 1'b0);
    apb(1'b0, vbc_pkg::OFF_READBACK, 32'h0);
    chk("abort busy", rd[10], 1'b0);
    chk("abort band", rd[6:0], 7'h3c);
    apb(1'b1, vbc_pkg::OFF_IRQ_STAT, 32'h7);
    $display("abort test done");
    // masked event sets status only
    apb(1'b1, vbc_pkg::OFF_IRQ_MASK, 32'h0);
    apb(1'b1, vbc_pkg::OFF_CTRL, 32'h10);
    stop <= 8'h05;
    kick();
    rd = 32'h0;
    for (int n = 0; n < 100 && rd[0] !== 1'b1; n++) apb(1'b0, vbc_pkg::OFF_IRQ_STAT, 32'h0);
    chk("done stat", rd[0], 1'b1);
    chk("masked irq", irq, 1'b0);
    apb(1'b1, vbc_pkg::OFF_IRQ_MASK, 32'h1);
    chk("unmasked irq", irq, 1'b1);
    $display("mask test done");
    // reset in mid-run
    kick();
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("reset lock", pll_lock, 1'b0);
    chk("reset irq", irq, 1'b0);
    apb(1'b0, vbc_pkg::OFF_READBACK, 32'h0);
    chk("reset result", rd[8:0], 9'h000);
    $display("second reset test done");
    results();
  end
endmodule
